// *** src/upc_map.vh ***
// Register map, field positions and mode codes of the serial protocol parameter block.
// Assumes one AHB-Lite slave with word-aligned 32-bit registers.
`ifndef UPC_MAP_VH
`define UPC_MAP_VH
`define UPC_OFS_PARAM_LOW 8'h00
`define UPC_OFS_PARAM_HIGH 8'h04
`define UPC_OFS_TX_SUM 8'h08
`define UPC_OFS_RX_SUM 8'h0c
`define UPC_OFS_CTRL 8'h10
`define UPC_OFS_STATUS 8'h14
`define UPC_CTRL_MODE_LSB 0
`define UPC_CTRL_MODE_MSB 2
`define UPC_CTRL_SUM_OPT 3
`define UPC_CTRL_BRK_REQ 4
`define UPC_CTRL_WAKE_EN 5
`define UPC_MODE_ASYNC 3'h0
`define UPC_MODE_ADDR 3'h1
`define UPC_MODE_LIN 3'h2
`define UPC_MODE_DMX 3'h3
`define UPC_MODE_DALI_DEV 3'h4
`define UPC_MODE_DALI_GEAR 3'h5
`define UPC_PID_MASK 8'h3f
`define UPC_RST_BYTE 8'h00
`define UPC_HTRANS_NONSEQ 2'h2
`endif

// *** src/upc_sum.v ***
// One modulo-256 checksum accumulator with software write and clear.
// Assumes byte strobes on the system clock; clear and add never conflict silently.
`timescale 1ns/1ns
`include "upc_map.vh"
module upc_sum
(
	input wire i_clk_sys,
	input wire i_sys_rst,
	input wire i_ce,
	input wire i_wr,
	input wire [7:0] i_wdata,
	input wire i_add,
	input wire [7:0] i_byte,
	output reg [7:0] o_sum
);
	// Write loads value (zero clears); a same-cycle byte is added on top
	always @(posedge i_clk_sys or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			o_sum <= `UPC_RST_BYTE;
		else if (i_ce)
		begin
			if (i_wr && i_add)
				o_sum <= i_wdata + i_byte;
			else if (i_wr)
				o_sum <= i_wdata;
			else if (i_add)
				o_sum <= o_sum + i_byte;
		end
	end
endmodule // upc_sum

// *** src/upc_cnt.v ***
// Loadable down counter used for slot counts and half-bit delays.
// Assumes the tick input is one cycle wide on the system clock.
`timescale 1ns/1ns
module upc_cnt
#(
	parameter WIDTH = 9
)
(
	input wire i_clk_sys,
	input wire i_sys_rst,
	input wire i_ce,
	input wire i_load,
	input wire [WIDTH-1:0] i_value,
	input wire i_tick,
	output reg o_busy,
	output wire o_done
);
	reg [WIDTH-1:0] count_r;
	assign o_done = o_busy && i_tick && (count_r <= {{(WIDTH-1){1'b0}}, 1'b1});
	// Count ticks down from the loaded value
	always @(posedge i_clk_sys or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			count_r <= {WIDTH{1'b0}};
			o_busy <= 1'b0;
		end
		else if (i_ce)
		begin
			if (i_load)
			begin
				count_r <= i_value;
				o_busy <= 1'b1;
			end
			else if (o_done)
				o_busy <= 1'b0;
			else if (o_busy && i_tick)
				count_r <= count_r - {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end
endmodule // upc_cnt

// *** src/upc_top.v ***
// Protocol parameter, checksum and protocol sequencing control of a serial port.
// Assumes AHB-Lite master on i_clk_sys, and a framing engine that consumes
// the byte requests and reports each byte sent or received with a strobe.
`timescale 1ns/1ns
`include "upc_map.vh"
module upc_top
(
	input wire i_clk_sys,
	input wire i_sys_rst,
	input wire i_ce,
	input wire i_sleep,
	input wire i_hsel,
	input wire [7:0] i_haddr,
	input wire [1:0] i_htrans,
	input wire i_hwrite,
	input wire [2:0] i_hsize,
	input wire [31:0] i_hwdata,
	input wire i_hready,
	output wire o_hreadyout,
	output wire o_hresp,
	output reg [31:0] o_hrdata,
	input wire i_tx_done,
	input wire [7:0] i_tx_byte,
	input wire i_tx_is_pid,
	input wire i_tx_is_start,
	input wire i_rx_done,
	input wire [7:0] i_rx_byte,
	input wire i_rx_is_pid,
	input wire i_half_bit,
	input wire i_rx_fwd_end,
	input wire i_dev_frame_req,
	output wire o_port_en,
	output reg o_auto_break,
	output reg o_sw_break,
	output reg [8:0] o_addr_char,
	output reg o_addr_valid,
	output reg [7:0] o_pid,
	output reg o_fwd_go,
	output reg o_back_go,
	output reg o_wake_en
);
	reg [7:0] param_low_r;
	reg param_high_r;
	reg [7:0] ctrl_r;
	reg wr_pend_r;
	reg [7:0] wr_addr_r;
	reg rd_pend_r;
	reg [7:0] rd_addr_r;
	reg sleep_s1_r;
	reg sleep_s2_r;
	reg lin_mode_r;
	reg dmx_mode_r;
	wire [2:0] mode;
	wire sum_opt;
	wire [8:0] param;
	wire active;
	wire tx_ev;
	wire rx_ev;
	wire tx_add;
	wire rx_add;
	wire tx_sum_wr;
	wire rx_sum_wr;
	wire [7:0] tx_sum;
	wire [7:0] rx_sum;
	wire addr_phase;
	wire slot_busy;
	wire slot_done;
	wire dly_busy;
	wire dly_done;
	wire dly_load;
	wire dly_tick;
	reg dly_gear_r;
	wire sw_grant;
	assign mode = ctrl_r[`UPC_CTRL_MODE_MSB:`UPC_CTRL_MODE_LSB];
	// Software Break granted once, straight from the live mode field
	assign sw_grant = active && ctrl_r[`UPC_CTRL_BRK_REQ] && (mode != `UPC_MODE_LIN)
		&& (mode != `UPC_MODE_DMX);
	assign sum_opt = ctrl_r[`UPC_CTRL_SUM_OPT];
	assign param = {param_high_r, param_low_r};
	assign o_hreadyout = 1'b1;
	assign o_hresp = 1'b0;
	// Sleep pin crosses in through two flops
	always @(posedge i_clk_sys or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			sleep_s1_r <= 1'b0;
			sleep_s2_r <= 1'b0;
		end
		else if (i_ce)
		begin
			sleep_s1_r <= i_sleep;
			sleep_s2_r <= sleep_s1_r;
		end
	end
	// Port halted in Sleep; only wake-on-break remains armed
	assign active = !sleep_s2_r;
	assign o_port_en = active;
	assign tx_ev = active && i_tx_done;
	assign rx_ev = active && i_rx_done;
	// Bus address phase capture
	assign addr_phase = i_hsel && i_hready && (i_htrans == `UPC_HTRANS_NONSEQ);
	always @(posedge i_clk_sys or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			wr_pend_r <= 1'b0;
			rd_pend_r <= 1'b0;
			wr_addr_r <= `UPC_RST_BYTE;
			rd_addr_r <= `UPC_RST_BYTE;
		end
		else if (i_ce)
		begin
			wr_pend_r <= addr_phase && i_hwrite;
			rd_pend_r <= addr_phase && !i_hwrite;
			if (addr_phase)
			begin
				wr_addr_r <= i_haddr;
				rd_addr_r <= i_haddr;
			end
		end
	end
	// Register writes in the data phase
	always @(posedge i_clk_sys or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			param_low_r <= `UPC_RST_BYTE;
			param_high_r <= 1'b0;
			ctrl_r <= `UPC_RST_BYTE;
		end
		else if (i_ce)
		begin
			if (wr_pend_r && wr_addr_r == `UPC_OFS_PARAM_LOW)
				param_low_r <= i_hwdata[7:0];
			if (wr_pend_r && wr_addr_r == `UPC_OFS_PARAM_HIGH)
				param_high_r <= i_hwdata[0];
			if (wr_pend_r && wr_addr_r == `UPC_OFS_CTRL)
				ctrl_r <= i_hwdata[7:0];
			else if (sw_grant)
				ctrl_r[`UPC_CTRL_BRK_REQ] <= 1'b0;
		end
	end
	// Read data registered at the address phase, held for the data phase
	always @(posedge i_clk_sys or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			o_hrdata <= 32'h0000_0000;
		else if (i_ce && addr_phase && !i_hwrite)
		begin
			case (i_haddr)
				`UPC_OFS_PARAM_LOW: o_hrdata <= {24'h000000, param_low_r};
				`UPC_OFS_PARAM_HIGH: o_hrdata <= {31'h00000000, param_high_r};
				`UPC_OFS_TX_SUM: o_hrdata <= {24'h000000, tx_sum};
				`UPC_OFS_RX_SUM: o_hrdata <= {24'h000000, rx_sum};
				`UPC_OFS_CTRL: o_hrdata <= {24'h000000, ctrl_r};
				`UPC_OFS_STATUS: o_hrdata <= {28'h0000000, dly_busy, slot_busy,
					dmx_mode_r, active};
				default: o_hrdata <= 32'h0000_0000;
			endcase
		end
	end
	// Registered mode decode
	always @(posedge i_clk_sys or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			lin_mode_r <= 1'b0;
			dmx_mode_r <= 1'b0;
		end
		else if (i_ce)
		begin
			lin_mode_r <= (mode == `UPC_MODE_LIN);
			dmx_mode_r <= (mode == `UPC_MODE_DMX);
		end
	end
	// Which bytes enter the sums
	assign tx_add = tx_ev && sum_opt;
	assign rx_add = rx_ev && (lin_mode_r ? (sum_opt || !i_rx_is_pid) : sum_opt);
	assign tx_sum_wr = wr_pend_r && wr_addr_r == `UPC_OFS_TX_SUM;
	assign rx_sum_wr = wr_pend_r && wr_addr_r == `UPC_OFS_RX_SUM;
	wire tx_add_lin0;
	assign tx_add_lin0 = tx_ev && lin_mode_r && !sum_opt && !i_tx_is_pid;
	upc_sum u_tx_sum
	(
		.i_clk_sys(i_clk_sys),
		.i_sys_rst(i_sys_rst),
		.i_ce(i_ce),
		.i_wr(tx_sum_wr),
		.i_wdata(i_hwdata[7:0]),
		.i_add(tx_add || tx_add_lin0),
		.i_byte(i_tx_byte),
		.o_sum(tx_sum)
	);
	upc_sum u_rx_sum
	(
		.i_clk_sys(i_clk_sys),
		.i_sys_rst(i_sys_rst),
		.i_ce(i_ce),
		.i_wr(rx_sum_wr),
		.i_wdata(i_hwdata[7:0]),
		.i_add(rx_add),
		.i_byte(i_rx_byte),
		.o_sum(rx_sum)
	);
	// DMX slot counter: loaded by start code, counts data bytes
	upc_cnt #(.WIDTH(9)) u_slot
	(
		.i_clk_sys(i_clk_sys),
		.i_sys_rst(i_sys_rst),
		.i_ce(i_ce),
		.i_load(tx_ev && dmx_mode_r && i_tx_is_start),
		.i_value(param),
		.i_tick(tx_ev && !i_tx_is_start),
		.o_busy(slot_busy),
		.o_done(slot_done)
	);
	// DALI delay counter in half-bit ticks
	assign dly_load = active && (((mode == `UPC_MODE_DALI_DEV) && i_dev_frame_req) ||
		((mode == `UPC_MODE_DALI_GEAR) && i_rx_fwd_end));
	assign dly_tick = active && i_half_bit;
	upc_cnt #(.WIDTH(9)) u_dly
	(
		.i_clk_sys(i_clk_sys),
		.i_sys_rst(i_sys_rst),
		.i_ce(i_ce),
		.i_load(dly_load),
		.i_value(param),
		.i_tick(dly_tick),
		.o_busy(dly_busy),
		.o_done(dly_done)
	);
	// Protocol output strobes and data
	always @(posedge i_clk_sys or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			dly_gear_r <= 1'b0;
			o_auto_break <= 1'b0;
			o_sw_break <= 1'b0;
			o_fwd_go <= 1'b0;
			o_back_go <= 1'b0;
			o_addr_char <= 9'h000;
			o_addr_valid <= 1'b0;
			o_pid <= `UPC_RST_BYTE;
			o_wake_en <= 1'b0;
		end
		else if (i_ce)
		begin
			if (dly_load)
				dly_gear_r <= (mode == `UPC_MODE_DALI_GEAR);
			o_auto_break <= active && dmx_mode_r && slot_done;
			o_sw_break <= sw_grant;
			o_fwd_go <= dly_done && !dly_gear_r;
			o_back_go <= dly_done && dly_gear_r;
			o_addr_char <= {1'b1, param_low_r};
			o_addr_valid <= active && (mode == `UPC_MODE_ADDR);
			o_pid <= param_low_r & `UPC_PID_MASK;
			o_wake_en <= ctrl_r[`UPC_CTRL_WAKE_EN];
		end
	end
endmodule // upc_top

// *** bench/upc_far_model.sv ***
// Far-side framing model: byte strobes and half-bit timing events.
// Assumes the bench calls its tasks on the system clock.
`timescale 1ns/1ns
module upc_far_model
(
	input wire i_clk_sys,
	output logic o_txs = 1'b0,
	output logic [7:0] o_txb = 8'h00,
	output logic o_txp = 1'b0,
	output logic o_txst = 1'b0,
	output logic o_rxs = 1'b0,
	output logic [7:0] o_rxb = 8'h00,
	output logic o_rxp = 1'b0,
	output logic [2:0] o_ev = 3'h0
);
	// One sent byte; byte lines show the inverse once released
	task automatic send_tx(input logic [7:0] v, input logic pid, input logic st);
		@(posedge i_clk_sys);
		o_txs <= 1'b1;
		o_txb <= v;
		o_txp <= pid;
		o_txst <= st;
		@(posedge i_clk_sys);
		o_txs <= 1'b0;
		o_txb <= ~v;
		o_txp <= 1'b0;
		o_txst <= 1'b0;
	endtask
	// One received byte
	task automatic send_rx(input logic [7:0] v, input logic pid);
		@(posedge i_clk_sys);
		o_rxs <= 1'b1;
		o_rxb <= v;
		o_rxp <= pid;
		@(posedge i_clk_sys);
		o_rxs <= 1'b0;
		o_rxb <= ~v;
		o_rxp <= 1'b0;
	endtask
	// Pulses of frame events: bit 0 frame request, 1 forward end, 2 half bit
	task automatic ev(input int k, input int n);
		repeat (n)
		begin
			@(posedge i_clk_sys);
			o_ev[k] <= 1'b1;
			@(posedge i_clk_sys);
			o_ev[k] <= 1'b0;
		end
	endtask
endmodule // upc_far_model

// *** bench/upc_top_asserts.sv ***
// Port checker of the protocol parameter block.
// Assumes one clock domain and an active high reset.
`timescale 1ns/1ns
module upc_top_chk
(
	input wire i_clk_sys,
	input wire i_sys_rst,
	input wire i_sleep,
	input wire i_hsel,
	input wire [1:0] i_htrans,
	input wire i_hready,
	input wire i_tx_done,
	input wire i_half_bit,
	input wire o_hreadyout,
	input wire o_hresp,
	input wire o_port_en,
	input wire o_auto_break,
	input wire o_sw_break,
	input wire [8:0] o_addr_char,
	input wire o_addr_valid,
	input wire [7:0] o_pid,
	input wire o_fwd_go,
	input wire o_back_go
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_sys_rst);
	// Bus, parameter and sleep relations
	property p_okay; i_hsel && i_htrans == 2'h2 && i_hready |=> o_hreadyout && !o_hresp; endproperty
	a_okay: assert property (p_okay) else $error("bus answer");
	property p_pid; o_pid != 8'h00 |-> o_pid[7:6] == 2'b00; endproperty
	a_pid: assert property (p_pid) else $error("pid high bits");
	property p_addr; o_addr_valid |-> o_addr_char[8] && o_port_en; endproperty
	a_addr: assert property (p_addr) else $error("address ninth bit");
	property p_sleep; i_sleep [*4] |-> !o_port_en; endproperty
	a_sleep: assert property (p_sleep) else $error("awake in sleep");
	property p_quiet; !o_port_en [*2] |-> !(o_auto_break || o_fwd_go || o_back_go || o_sw_break); endproperty
	a_quiet: assert property (p_quiet) else $error("activity in sleep");
	// Timed pulses follow their cause by one cycle
	property p_auto; o_auto_break |-> $past(i_tx_done) ##1 !o_auto_break; endproperty
	a_auto: assert property (p_auto) else $error("auto break");
	property p_fwd; o_fwd_go |-> $past(i_half_bit) ##1 !o_fwd_go; endproperty
	a_fwd: assert property (p_fwd) else $error("forward go");
	property p_back; o_back_go |-> $past(i_half_bit) ##1 !o_back_go; endproperty
	a_back: assert property (p_back) else $error("back go");
	c_auto: cover property (o_auto_break);
	c_fwd: cover property (o_fwd_go);
	c_back: cover property (o_back_go);
endmodule // upc_top_chk
bind upc_top upc_top_chk chk_u (.*);

// *** bench/tb_uart_parameter_and_checksum.sv ***
// Self-checking bench of the protocol parameter and checksum block.
// Assumes the far-side model drives byte strobes and frame events.
`timescale 1ns/1ns
module tb_uart_parameter_and_checksum;
	logic i_clk_sys = 1'b0;
	logic i_sys_rst = 1'b1;
	logic i_sleep = 1'b0;
	logic i_hsel = 1'b0;
	logic i_hwrite = 1'b0;
	logic [7:0] i_haddr = 8'h00;
	logic [1:0] i_htrans = 2'h0;
	logic [31:0] i_hwdata = 32'h0;
	wire o_hreadyout, o_hresp, o_port_en, o_auto_break, o_sw_break, o_addr_valid;
	wire o_fwd_go, o_back_go, o_wake_en, i_tx_done, i_tx_is_pid, i_tx_is_start, i_rx_done;
	wire i_rx_is_pid;
	wire [31:0] o_hrdata;
	wire [8:0] o_addr_char;
	wire [7:0] o_pid, i_tx_byte, i_rx_byte;
	wire [2:0] ev;
	int miscompares = 0, check_count = 0, n_auto = 0, n_sw = 0, n_go[2] = '{0, 0};
	logic [31:0] rd;
	logic [7:0] p, s_tx, s_rx, b;
	upc_top dut_u (.i_hready(o_hreadyout), .i_hsize(3'h2), .i_ce(1'b1), .i_dev_frame_req(ev[0]),
		.i_rx_fwd_end(ev[1]), .i_half_bit(ev[2]), .*);
	upc_far_model far_u (.i_clk_sys, .o_txs(i_tx_done), .o_txb(i_tx_byte), .o_txp(i_tx_is_pid),
		.o_txst(i_tx_is_start), .o_rxs(i_rx_done), .o_rxb(i_rx_byte), .o_rxp(i_rx_is_pid), .o_ev(ev));
	always #10 i_clk_sys = ~i_clk_sys;
	// Pulse counters of timed outputs
	always @(posedge i_clk_sys)
	begin
		n_auto += o_auto_break;
		n_sw += o_sw_break;
		n_go[0] += o_fwd_go;
		n_go[1] += o_back_go;
	end
	// One AHB single transfer, read data taken at the data-phase edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk_sys);
		i_hsel <= 1'b1;
		i_htrans <= 2'h2;
		i_hwrite <= w;
		i_haddr <= a;
		do @(posedge i_clk_sys); while (o_hreadyout !== 1'b1);
		i_htrans <= 2'h0;
		i_hsel <= 1'b0;
		i_hwdata <= d;
		do @(posedge i_clk_sys); while (o_hreadyout !== 1'b1);
		rd = o_hrdata;
	endtask
	task automatic cmp_reg(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e)
		begin
			miscompares++;
			$display("mismatch at %0t: value %h want %h", $time, g, e);
		end
	endtask
	task automatic cmp_cnt(input int g, input int e);
		check_count++;
		if (g != e)
		begin
			miscompares++;
			$display("mismatch at %0t: count %0d want %0d", $time, g, e);
		end
	endtask
	// Whether a byte joins the sum, by mode, option and identifier flag
	function automatic bit f_add(input bit lin, input bit opt, input bit pid);
		return opt || (lin && !pid);
	endfunction
	task automatic print_verdict;
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Watchdog
	initial
	begin
		#400000;
		miscompares++;
		print_verdict;
	end
	// Main sequence
	initial
	begin
		void'($urandom(32'h7930));
		repeat (8) @(posedge i_clk_sys);
		i_sys_rst <= 1'b0;
		for (int k = 0; k < 5; k++)
		begin
			bus(1'b0, 8'(k * 4 + ((k == 4) ? 32'h30 : 0)), 32'h0);
			cmp_reg(rd, 32'h0);
		end
		bus(1'b1, 8'h40, 32'hffff_ffff);
		bus(1'b1, 8'h04, 32'hffff_ffff);
		bus(1'b0, 8'h04, 32'h0);
		cmp_reg(rd, 32'h1);
		p = 8'($urandom);
		bus(1'b1, 8'h00, {24'h0, p});
		bus(1'b0, 8'h00, 32'h0);
		cmp_reg(rd, {24'h0, p});
		bus(1'b1, 8'h10, 32'h1);
		repeat (3) @(posedge i_clk_sys);
		cmp_reg({22'h0, o_addr_valid, o_addr_char}, {22'h0, 2'b11, p});
		cmp_reg({24'h0, o_pid}, {24'h0, p & 8'h3f});
		// Sums in async and LIN, option clear and set, with wrap
		for (int m = 0; m < 4; m++)
		begin
			bus(1'b1, 8'h10, {28'h0, m[1], 1'b0, m[0], 1'b0});
			bus(1'b1, 8'h08, 32'h0);
			bus(1'b1, 8'h0c, 32'h0);
			s_tx = 8'h00;
			s_rx = 8'h00;
			for (int i = 0; i < 6; i++)
			begin
				b = 8'($urandom);
				far_u.send_tx(b, i == 0, 1'b0);
				s_tx += f_add(m[0], m[1], i == 0) ? b : 8'h00;
				b = 8'($urandom);
				far_u.send_rx(b, i == 0);
				s_rx += f_add(m[0], m[1], i == 0) ? b : 8'h00;
			end
			bus(1'b0, 8'h08, 32'h0);
			cmp_reg(rd, {24'h0, s_tx});
			bus(1'b0, 8'h0c, 32'h0);
			cmp_reg(rd, {24'h0, s_rx});
		end
		// DMX slot count, software Break refused then granted outside DMX
		p = 8'(2 + $urandom % 4);
		bus(1'b1, 8'h04, 32'h0);
		bus(1'b1, 8'h00, {24'h0, p});
		bus(1'b1, 8'h10, 32'h3);
		bus(1'b1, 8'h10, 32'h13);
		far_u.send_tx(8'h00, 1'b0, 1'b1);
		repeat (p - 1) far_u.send_tx(8'(~p), 1'b0, 1'b0);
		cmp_cnt(n_auto, 0);
		far_u.send_tx(p, 1'b0, 1'b0);
		repeat (3) @(posedge i_clk_sys);
		cmp_cnt(n_auto, 1);
		cmp_cnt(n_sw, 0);
		bus(1'b1, 8'h10, 32'h10);
		repeat (4) @(posedge i_clk_sys);
		cmp_cnt(n_sw, 1);
		// DALI delays in half bits, device then gear
		for (int k = 0; k < 2; k++)
		begin
			bus(1'b1, 8'h10, 32'(4 + k));
			repeat (2) @(posedge i_clk_sys);
			far_u.ev(k, 1);
			far_u.ev(2, p - 1);
			cmp_cnt(n_go[k], 0);
			far_u.ev(2, 1);
			repeat (3) @(posedge i_clk_sys);
			cmp_cnt(n_go[k], 1);
		end
		// Wake enable bit reaches its output
		bus(1'b1, 8'h10, 32'h25);
		repeat (2) @(posedge i_clk_sys);
		cmp_reg({31'h0, o_wake_en}, 32'h1);
		// Sleep stops the gear delay
		i_sleep <= 1'b1;
		repeat (4) @(posedge i_clk_sys);
		cmp_reg({31'h0, o_port_en}, 32'h0);
		far_u.ev(1, 1);
		far_u.ev(2, p + 1);
		cmp_cnt(n_go[1], 1);
		i_sleep <= 1'b0;
		print_verdict;
	end
endmodule // tb_uart_parameter_and_checksum
